/* File: srb_pkg.sv */
// =====================================================================
// shared constants for the readback and output configuration block
// =====================================================================
package srb_pkg;

    localparam int WORD_W = 32;

    // =================================================================
    // register addresses (low nibble of each serial word)
    // =================================================================
    localparam logic [3:0] ADDR_OUT_CTRL = 4'h5;
    localparam logic [3:0] ADDR_READBACK = 4'h6;
    localparam logic [3:0] ADDR_STATUS_PINS = 4'h7;

    // =================================================================
    // output_and_calibration_control fields
    // =================================================================
    localparam int OC_CLR_FB_BIT = 30;
    localparam int OC_CLR_REF_BIT = 29;
    localparam int OC_MUTE_BIT = 27;
    localparam int OC_REF_RANGE_LSB = 24;
    localparam int OC_BUF_IGNORE_BIT = 23;
    localparam int OC_POLICY_LSB = 21;
    localparam int OC_PRESET_LSB = 19;
    localparam int OC_OUTB_LSB = 17;

    // =================================================================
    // readback_and_diagnostics fields
    // =================================================================
    localparam int RD_DIAG_LSB = 4;
    localparam int RD_SEL_LSB = 24;
    localparam int RD_PART_SEL_BIT = 28;
    localparam int RD_LOCKOUT_BIT = 29;

    // status pin register field
    localparam int SP_CHOICE_LSB = 4;

    // =================================================================
    // diagnostic word bit positions
    // =================================================================
    localparam int DG_CORE_LSB = 18;
    localparam int DG_FB_SEEN = 17;
    localparam int DG_REF_SEEN = 16;
    localparam int DG_ACTIVITY = 15;
    localparam int DG_CAL_ACTIVE = 10;
    localparam int DG_FAIL_UPPER = 9;
    localparam int DG_FAIL_LOWER = 8;
    localparam int DG_TUNE_OVER = 6;
    localparam int DG_TUNE_IN_RANGE = 5;
    localparam int DG_QS_LOW = 4;
    localparam int DG_PHASE_LOCK = 3;
    localparam int DG_LOCK_PIN = 2;
    localparam int DG_CE = 1;
    localparam int DG_BUF_EN = 0;

    // tuning voltage limit of the external comparator, millivolts
    localparam int TUNE_LIMIT_MV = 2400;

    // =================================================================
    // values after reset
    // =================================================================
    localparam logic [3:0] RST_RB_SEL = 4'hf;
    localparam logic [4:0] RST_MUX_CHOICE = 5'h04;
    localparam logic [2:0] RST_REF_RANGE = 3'h0;
    localparam logic [1:0] RST_CORE = 2'h0;
    // clock cycles after reset before a pad level change counts as an edge
    localparam logic [2:0] PAD_SETTLE = 3'h4;

    // =================================================================
    // pad indices of synchronised inputs
    // =================================================================
    localparam int PAD_N = 6;
    localparam int PAD_REF = 0;
    localparam int PAD_FB = 1;
    localparam int PAD_CE = 2;
    localparam int PAD_BUF_EN = 3;
    localparam int PAD_LOCK = 4;
    localparam int PAD_QS = 5;

    typedef enum logic [1:0] {
        POL_LAST = 2'b00,
        POL_PRESET = 2'b01,
        POL_FORCE = 2'b10,
        POL_RSVD = 2'b11
    } srb_policy_t;

    typedef enum logic [1:0] {
        OUTB_CORE = 2'b00,
        OUTB_DIVIDED = 2'b01,
        OUTB_FEEDBACK = 2'b10,
        OUTB_RSVD = 2'b11
    } srb_outb_t;

    // status mux choices
    localparam logic [4:0] MUX_GND = 5'h00;
    localparam logic [4:0] MUX_LOCK_DET = 5'h01;
    localparam logic [4:0] MUX_VTUNE = 5'h02;
    localparam logic [4:0] MUX_BOTH = 5'h03;
    localparam logic [4:0] MUX_READBACK = 5'h04;
    localparam logic [4:0] MUX_REF_SEEN = 5'h0a;
    localparam logic [4:0] MUX_FB_SEEN = 5'h0b;
    localparam logic [4:0] MUX_CAL = 5'h0c;
    localparam logic [4:0] MUX_TUNE_BAD = 5'h0d;
    localparam logic [4:0] MUX_FAIL_LO = 5'h0e;
    localparam logic [4:0] MUX_FAIL_HI = 5'h0f;

    // three-stage synchroniser filter: follow once stages two and three agree
    function automatic logic srb_filt(input logic s1, input logic s2, input logic old);
        srb_filt = (s1 == s2) ? s2 : old;
    endfunction : srb_filt

endpackage : srb_pkg

/* File: srb_serial_if.sv */
`timescale 1ns/10ps
// =====================================================================
// word and strobes from the serial front end to the register bank
// =====================================================================
interface srb_serial_if;
    logic [31:0] word;
    logic latch;
    logic shift_out;
    modport src (output word, output latch, output shift_out);
    modport snk (input word, input latch, input shift_out);
endinterface : srb_serial_if

/* File: srb_serial_rx.sv */
`timescale 1ns/10ps
module srb_serial_rx
    import srb_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic ser_clk, // serial port clock pin
    input wire logic ser_data, // serial port data pin
    input wire logic ser_le, // serial port latch enable pin
    srb_serial_if.src sp // word and strobes out
);
    typedef struct packed {
        logic [2:0] ck_s;
        logic [2:0] da_s;
        logic [2:0] le_s;
        logic ck_f;
        logic da_f;
        logic le_f;
        logic [31:0] shreg;
        logic latch;
        logic fall;
    } srb_rx_st_t;

    srb_rx_st_t st_q;
    srb_rx_st_t st_d;

    // =================================================================
    // sampling, edge detection and shifting
    // =================================================================
    always_comb begin
        st_d = st_q;
        st_d.ck_s = {st_q.ck_s[1:0], ser_clk};
        st_d.da_s = {st_q.da_s[1:0], ser_data};
        st_d.le_s = {st_q.le_s[1:0], ser_le};
        st_d.ck_f = srb_filt(st_q.ck_s[1], st_q.ck_s[2], st_q.ck_f);
        st_d.da_f = srb_filt(st_q.da_s[1], st_q.da_s[2], st_q.da_f);
        st_d.le_f = srb_filt(st_q.le_s[1], st_q.le_s[2], st_q.le_f);
        st_d.latch = st_d.le_f & ~st_q.le_f;
        st_d.fall = ~st_d.ck_f & st_q.ck_f;
        // msb first, data taken on the rising serial clock
        if (st_d.ck_f & ~st_q.ck_f) begin
            st_d.shreg = {st_q.shreg[30:0], st_q.da_f};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sp.word = st_q.shreg;
    assign sp.latch = st_q.latch;
    assign sp.shift_out = st_q.fall;

endmodule : srb_serial_rx

/* File: srb_config_top.sv */
`timescale 1ns/10ps
module srb_config_top
    import srb_pkg::*;
#(
    parameter int NUM_CORES = 4, // oscillator cores
    parameter logic [1:0] LOWEST_CORE = 2'h0, // core of lowest frequency
    parameter logic [31:0] PART_CODE = 32'h0000_5a5a // arbitrary value
) (
    input wire logic clk_sys, // system clock, 25 MHz
    input wire logic resetn, // async reset, active low
    input wire logic ser_clk, // serial port clock pin
    input wire logic ser_data, // serial port data pin
    input wire logic ser_le, // serial port latch enable pin
    input wire logic ref_input_pin, // reference input pad
    input wire logic fb_input_pin, // feedback input pad
    input wire logic chip_enable_pin, // chip enable pad
    input wire logic buffer_enable_pin, // buffer enable pad
    input wire logic lock_pin, // lock indicator pad level
    input wire logic quick_settle_pin, // quick settle pad level
    input wire logic [1:0] chosen_core, // core picked by calibration
    input wire logic core_activity_seen, // core activity detector
    input wire logic cal_active, // calibration in progress
    input wire logic cal_fail_up_evt, // pulse: failed needing higher freq
    input wire logic cal_fail_lo_evt, // pulse: failed needing lower freq
    input wire logic core_preset_valid, // preset core can reach target
    input wire logic tune_volt_over, // tuning voltage above limit
    input wire logic tune_volt_in_range, // tuning voltage in range
    input wire logic phase_lock_flag, // phase detector lock state
    output logic status_mux_pin, // status pin data
    output logic rf_out_a_en, // output buffer A enable
    output logic rf_out_b_en, // output buffer B enable
    output logic [1:0] out_b_source, // output B source
    output logic [2:0] ref_range, // reference range to calibration
    output logic [1:0] cal_start_core, // first core for calibration
    output logic cal_fallback_en // calibration may try other cores
);
    if (NUM_CORES != 4) begin : g_chk
        $error("srb_config_top serves four cores only");
    end

    typedef struct packed {
        logic [PAD_N-1:0][2:0] pad_s;
        logic [PAD_N-1:0] pad_f;
        logic [2:0] settle;
        logic fb_seen;
        logic ref_seen;
        logic fail_up;
        logic fail_lo;
        logic cal_prev;
        logic last_valid;
        logic [1:0] last_core;
        logic clr_fb;
        logic clr_ref;
        logic mute;
        logic [2:0] ref_rng;
        logic buf_ignore;
        logic [1:0] policy;
        logic [1:0] preset;
        logic [1:0] outb;
        logic [3:0] rb_sel;
        logic part_sel;
        logic lockout;
        logic [4:0] mux_choice;
        logic [31:0] rb_shift;
        logic mux_out;
        logic buf_a;
        logic buf_b;
        logic [1:0] outb_o;
        logic [1:0] start_core;
        logic fallback;
    } srb_st_t;

    srb_st_t st_q;
    srb_st_t st_d;
    srb_serial_if sp ();

    logic [PAD_N-1:0] pad_in;
    logic [19:0] diag;

    assign pad_in[PAD_REF] = ref_input_pin;
    assign pad_in[PAD_FB] = fb_input_pin;
    assign pad_in[PAD_CE] = chip_enable_pin;
    assign pad_in[PAD_BUF_EN] = buffer_enable_pin;
    assign pad_in[PAD_LOCK] = lock_pin;
    assign pad_in[PAD_QS] = quick_settle_pin;

    srb_serial_rx u_rx (
        .clk_sys (clk_sys),
        .resetn (resetn),
        .ser_clk (ser_clk),
        .ser_data (ser_data),
        .ser_le (ser_le),
        .sp (sp.src)
    );

    // =================================================================
    // diagnostic word
    // =================================================================
    always_comb begin
        diag = '0;
        diag[DG_CORE_LSB +: 2] = chosen_core;
        diag[DG_FB_SEEN] = st_q.fb_seen;
        diag[DG_REF_SEEN] = st_q.ref_seen;
        diag[DG_ACTIVITY] = core_activity_seen;
        diag[DG_CAL_ACTIVE] = cal_active;
        diag[DG_FAIL_UPPER] = st_q.fail_up;
        diag[DG_FAIL_LOWER] = st_q.fail_lo;
        diag[DG_TUNE_OVER] = tune_volt_over;
        diag[DG_TUNE_IN_RANGE] = tune_volt_in_range;
        diag[DG_QS_LOW] = ~st_q.pad_f[PAD_QS];
        diag[DG_PHASE_LOCK] = phase_lock_flag;
        diag[DG_LOCK_PIN] = st_q.pad_f[PAD_LOCK];
        diag[DG_CE] = st_q.pad_f[PAD_CE];
        diag[DG_BUF_EN] = st_q.pad_f[PAD_BUF_EN];
    end

    // register images as read back
    function automatic logic [31:0] img_out_ctrl(input srb_st_t s);
        logic [31:0] w;
        w = '0;
        w[OC_CLR_FB_BIT] = s.clr_fb;
        w[OC_CLR_REF_BIT] = s.clr_ref;
        w[OC_MUTE_BIT] = s.mute;
        w[OC_REF_RANGE_LSB +: 3] = s.ref_rng;
        w[OC_BUF_IGNORE_BIT] = s.buf_ignore;
        w[OC_POLICY_LSB +: 2] = s.policy;
        w[OC_PRESET_LSB +: 2] = s.preset;
        w[OC_OUTB_LSB +: 2] = s.outb;
        w[3:0] = ADDR_OUT_CTRL;
        img_out_ctrl = w;
    endfunction : img_out_ctrl

    function automatic logic [31:0] img_readback(input srb_st_t s, input logic [19:0] dg);
        logic [31:0] w;
        w = '0;
        w[RD_LOCKOUT_BIT] = s.lockout;
        w[RD_PART_SEL_BIT] = s.part_sel;
        w[RD_SEL_LSB +: 4] = s.rb_sel;
        w[RD_DIAG_LSB +: 20] = dg;
        w[3:0] = ADDR_READBACK;
        img_readback = w;
    endfunction : img_readback

    // =================================================================
    // next state
    // =================================================================
    always_comb begin
        logic [31:0] wd;
        logic wr;
        logic [PAD_N-1:0] chg;
        logic clr_fb_pulse;
        logic clr_ref_pulse;
        logic cal_start;
        logic cal_end;
        logic locked_ok;
        logic buf_ok;
        wd = sp.word;
        wr = sp.latch;
        chg = '0;
        clr_fb_pulse = 1'b0;
        clr_ref_pulse = 1'b0;
        cal_start = 1'b0;
        cal_end = 1'b0;
        locked_ok = 1'b0;
        buf_ok = 1'b0;
        st_d = st_q;

        for (int i = 0; i < PAD_N; i++) begin
            st_d.pad_s[i] = {st_q.pad_s[i][1:0], pad_in[i]};
            st_d.pad_f[i] = srb_filt(st_q.pad_s[i][1], st_q.pad_s[i][2], st_q.pad_f[i]);
            chg[i] = st_d.pad_f[i] ^ st_q.pad_f[i];
        end
        // filters leave their reset level once real samples arrive; that step is no pin edge
        if (st_q.settle != PAD_SETTLE) begin
            st_d.settle = st_q.settle + 3'h1;
            chg = '0;
        end

        // =================================================================
        // serial writes
        // =================================================================
        if (wr) begin
            unique case (wd[3:0])
                ADDR_OUT_CTRL: begin
                    if (!st_q.lockout) begin
                        st_d.clr_fb = wd[OC_CLR_FB_BIT];
                        st_d.clr_ref = wd[OC_CLR_REF_BIT];
                        st_d.mute = wd[OC_MUTE_BIT];
                        st_d.ref_rng = wd[OC_REF_RANGE_LSB +: 3];
                        st_d.buf_ignore = wd[OC_BUF_IGNORE_BIT];
                        st_d.policy = wd[OC_POLICY_LSB +: 2];
                        st_d.preset = wd[OC_PRESET_LSB +: 2];
                        st_d.outb = wd[OC_OUTB_LSB +: 2];
                    end
                end
                ADDR_READBACK: begin
                    st_d.lockout = wd[RD_LOCKOUT_BIT];
                    if (!st_q.lockout) begin
                        st_d.part_sel = wd[RD_PART_SEL_BIT];
                        st_d.rb_sel = wd[RD_SEL_LSB +: 4];
                    end
                end
                ADDR_STATUS_PINS: begin
                    if (!st_q.lockout) begin
                        st_d.mux_choice = wd[SP_CHOICE_LSB +: 5];
                    end
                end
                default: begin
                end
            endcase
        end

        // =================================================================
        // sticky input detectors, cleared by a one then zero write; set wins
        // =================================================================
        clr_fb_pulse = st_q.clr_fb & ~st_d.clr_fb;
        clr_ref_pulse = st_q.clr_ref & ~st_d.clr_ref;
        st_d.fb_seen = chg[PAD_FB] | (st_q.fb_seen & ~clr_fb_pulse);
        st_d.ref_seen = chg[PAD_REF] | (st_q.ref_seen & ~clr_ref_pulse);

        // calibration failure flags hold until the next calibration starts
        cal_start = cal_active & ~st_q.cal_prev;
        cal_end = ~cal_active & st_q.cal_prev;
        st_d.cal_prev = cal_active;
        st_d.fail_up = cal_fail_up_evt | (st_q.fail_up & ~cal_start);
        st_d.fail_lo = cal_fail_lo_evt | (st_q.fail_lo & ~cal_start);
        if (cal_end) begin
            st_d.last_valid = 1'b1;
            st_d.last_core = chosen_core;
        end

        // =================================================================
        // core pick policy
        // =================================================================
        unique case (srb_policy_t'(st_q.policy))
            POL_PRESET: begin
                st_d.start_core = st_q.preset;
                st_d.fallback = ~core_preset_valid;
            end
            POL_FORCE: begin
                st_d.start_core = st_q.preset;
                st_d.fallback = 1'b0;
            end
            POL_LAST, POL_RSVD: begin
                st_d.start_core = st_q.last_valid ? st_q.last_core : LOWEST_CORE;
                st_d.fallback = 1'b1;
            end
        endcase

        // =================================================================
        // output buffers
        // =================================================================
        // lock flag is used unsynchronised so a mute lands one cycle after unlock
        locked_ok = ~st_q.mute | phase_lock_flag;
        buf_ok = st_q.buf_ignore | st_q.pad_f[PAD_BUF_EN];
        st_d.buf_a = locked_ok & buf_ok;
        st_d.buf_b = locked_ok & buf_ok;
        st_d.outb_o = (srb_outb_t'(st_q.outb) == OUTB_RSVD) ? OUTB_CORE : st_q.outb;

        // =================================================================
        // readback load at the end of a frame, shifted in the next one
        // =================================================================
        // image takes the select just written, so a new select answers in the next frame
        if (wr) begin
            if (st_d.part_sel) begin
                st_d.rb_shift = PART_CODE;
            end else begin
                unique case (st_d.rb_sel)
                    ADDR_OUT_CTRL: st_d.rb_shift = img_out_ctrl(st_d);
                    ADDR_READBACK: st_d.rb_shift = img_readback(st_d, diag);
                    ADDR_STATUS_PINS: st_d.rb_shift = {23'h000000, st_d.mux_choice, ADDR_STATUS_PINS};
                    default: st_d.rb_shift = '0;
                endcase
            end
        end else if (sp.shift_out) begin
            st_d.rb_shift = {st_q.rb_shift[30:0], 1'b0};
        end

        // =================================================================
        // status pin
        // =================================================================
        case (st_q.mux_choice)
            MUX_READBACK: st_d.mux_out = st_q.rb_shift[31];
            MUX_LOCK_DET: st_d.mux_out = phase_lock_flag;
            MUX_VTUNE: st_d.mux_out = tune_volt_in_range;
            MUX_BOTH: st_d.mux_out = phase_lock_flag & tune_volt_in_range;
            MUX_REF_SEEN: st_d.mux_out = st_q.ref_seen;
            MUX_FB_SEEN: st_d.mux_out = st_q.fb_seen;
            MUX_CAL: st_d.mux_out = cal_active;
            MUX_TUNE_BAD: st_d.mux_out = ~tune_volt_in_range;
            MUX_FAIL_LO: st_d.mux_out = st_q.fail_lo;
            MUX_FAIL_HI: st_d.mux_out = st_q.fail_up;
            default: st_d.mux_out = 1'b0;
        endcase
    end

    // =================================================================
    // state register
    // =================================================================
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.rb_sel <= RST_RB_SEL;
            st_q.mux_choice <= RST_MUX_CHOICE;
            st_q.ref_rng <= RST_REF_RANGE;
            st_q.last_core <= RST_CORE;
            st_q.start_core <= LOWEST_CORE;
            st_q.fallback <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign status_mux_pin = st_q.mux_out;
    assign rf_out_a_en = st_q.buf_a;
    assign rf_out_b_en = st_q.buf_b;
    assign out_b_source = st_q.outb_o;
    assign ref_range = st_q.ref_rng;
    assign cal_start_core = st_q.start_core;
    assign cal_fallback_en = st_q.fallback;

endmodule : srb_config_top

/* File: srb_host_model.sv */
`timescale 1ns/10ps
// =====================================================================
// host side of the serial programming port
// =====================================================================
module srb_host_model (
    input wire logic clk_sys, // system clock
    output logic ser_clk, // serial clock, low outside frames
    output logic ser_data, // serial data
    output logic ser_le, // latch enable
    input wire logic status_mux_pin // readback data
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_le = 1'b0;
    end
    // word goes out msb first; the word loaded by the last latch comes back
    task automatic xfer(input logic [31:0] w, output logic [31:0] rd);
        @(posedge clk_sys);
        for (int i = 31; i >= 0; i--) begin
            ser_data <= w[i];
            repeat (4) @(posedge clk_sys);
            ser_clk <= 1'b1;
            repeat (3) @(posedge clk_sys);
            // read the status pin away from the edge that moves it
            @(negedge clk_sys) rd[i] = status_mux_pin;
            @(posedge clk_sys) ser_clk <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        ser_le <= 1'b1;
        repeat (16) @(posedge clk_sys);
        ser_le <= 1'b0;
        ser_data <= ~w[0];
        repeat (8) @(posedge clk_sys);
    endtask : xfer
endmodule : srb_host_model

/* File: srb_config_top_props.sv */
`timescale 1ns/10ps
module srb_config_top_props (
    input wire logic clk_sys, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic ser_le, // latch enable pin
    input wire logic cal_active, // calibration running
    input wire logic core_preset_valid, // preset core usable
    input wire logic status_mux_pin, // status pin
    input wire logic rf_out_a_en, // buffer a enable
    input wire logic rf_out_b_en, // buffer b enable
    input wire logic [1:0] out_b_source, // output b source
    input wire logic [2:0] ref_range, // reference range
    input wire logic [1:0] cal_start_core, // first core
    input wire logic cal_fallback_en // other cores allowed
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // =================================================================
    // output checks
    reset_vals_a: assert property (
        $rose(resetn) |-> cal_fallback_en && cal_start_core == 2'h0 && ref_range == 3'h0 && !rf_out_a_en)
        else $error("outputs wrong after reset");
    idle_pin_a: assert property ($rose(resetn) |-> !status_mux_pin [*4])
        else $error("status pin not idle after reset");
    outb_legal_a: assert property (out_b_source != 2'h3)
        else $error("reserved output b source shown");
    buf_pair_a: assert property (rf_out_a_en == rf_out_b_en)
        else $error("buffer enables differ");
    range_latch_a: assert property ($changed(ref_range) |-> ser_le)
        else $error("reference range changed outside a write");
    outb_latch_a: assert property ($changed(out_b_source) |-> ser_le)
        else $error("output b source changed outside a write");
    fallback_cause_a: assert property ($changed(cal_fallback_en) |-> ser_le ||
        $past(core_preset_valid) != $past(core_preset_valid, 2) ||
        $past(core_preset_valid, 2) != $past(core_preset_valid, 3))
        else $error("fallback changed without cause");
    start_cause_a: assert property ($changed(cal_start_core) |-> ser_le ||
        $past(cal_active) || $past(cal_active, 2) || $past(cal_active, 3))
        else $error("start core changed without cause");
endmodule : srb_config_top_props

/* File: synth_readback_and_output_config_test.sv */
`timescale 1ns/10ps
module synth_readback_and_output_config_test;
    import srb_pkg::*;
    logic clk_sys = 1'b0, resetn = 1'b0, ser_clk, ser_data, ser_le, status_mux_pin;
    logic ref_input_pin = 1'b0, fb_input_pin = 1'b0, chip_enable_pin = 1'b0, buffer_enable_pin = 1'b1;
    logic lock_pin = 1'b0, quick_settle_pin = 1'b0, core_activity_seen = 1'b0, cal_active = 1'b0;
    logic cal_fail_up_evt = 1'b0, cal_fail_lo_evt = 1'b0, core_preset_valid = 1'b1, tune_volt_over = 1'b0;
    logic tune_volt_in_range = 1'b0, phase_lock_flag = 1'b0, rf_out_a_en, rf_out_b_en, cal_fallback_en;
    logic [1:0] chosen_core = 2'h0, out_b_source, cal_start_core;
    logic [2:0] ref_range;
    logic [31:0] rd;
    logic [40:0] rows [5];
    int n_mismatch = 0, total_checks = 0;
    always #20 clk_sys = ~clk_sys;
    srb_host_model host (.clk_sys, .ser_clk, .ser_data, .ser_le, .status_mux_pin);
    srb_config_top #(.PART_CODE(32'h0000_1234)) dut ( // part code value is arbitrary
        .clk_sys, .resetn, .ser_clk, .ser_data, .ser_le, .ref_input_pin, .fb_input_pin, .chip_enable_pin,
        .buffer_enable_pin, .lock_pin, .quick_settle_pin, .chosen_core, .core_activity_seen, .cal_active,
        .cal_fail_up_evt, .cal_fail_lo_evt, .core_preset_valid, .tune_volt_over, .tune_volt_in_range,
        .phase_lock_flag, .status_mux_pin, .rf_out_a_en, .rf_out_b_en, .out_b_source, .ref_range,
        .cal_start_core, .cal_fallback_en);
    // =================================================================
    // helpers
    function automatic logic [31:0] mk5(input logic [4:0] hi, input logic [2:0] rng, input logic [6:0] lo);
        mk5 = {hi, rng, lo, 13'h0, ADDR_OUT_CTRL};
    endfunction : mk5
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    // =================================================================
    // stimulus
    initial begin
        // preset valid, control word, expected {out b, range, start core, fallback}
        rows = '{{1'b1, mk5(5'h00, 3'h0, 7'h18), 8'h04}, {1'b1, mk5(5'h00, 3'h1, 7'h2d), 8'h4e},
            {1'b1, mk5(5'h00, 3'h2, 7'h06), 8'h91}, {1'b1, mk5(5'h00, 3'h3, 7'h3b), 8'h19},
            {1'b0, mk5(5'h00, 3'h4, 7'h16), 8'ha3}};
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        foreach (rows[i]) begin
            core_preset_valid <= rows[i][40];
            host.xfer(rows[i][39:8], rd);
            chk(32'({out_b_source, ref_range, cal_start_core, cal_fallback_en}),
                32'(rows[i][7:0]));
        end
        host.xfer(32'h2f00_0006, rd);
        host.xfer(mk5(5'h00, 3'h1, 7'h01), rd);
        chk(32'(out_b_source), 32'h2);
        host.xfer(32'h0f00_0006, rd);
        host.xfer(mk5(5'h01, 3'h1, 7'h01), rd);
        chk(32'({out_b_source, rf_out_a_en, rf_out_b_en}), 32'h4);
        phase_lock_flag <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(32'({rf_out_a_en, rf_out_b_en}), 32'h3);
        buffer_enable_pin <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(32'({rf_out_a_en, rf_out_b_en}), 32'h0);
        host.xfer(mk5(5'h01, 3'h1, 7'h41), rd);
        chk(32'({rf_out_a_en, rf_out_b_en}), 32'h3);
        chosen_core <= 2'h3;
        core_activity_seen <= 1'b1;
        cal_active <= 1'b1;
        tune_volt_over <= 1'b1;
        lock_pin <= 1'b1;
        chip_enable_pin <= 1'b1;
        ref_input_pin <= 1'b1;
        fb_input_pin <= 1'b1;
        @(posedge clk_sys) cal_fail_up_evt <= 1'b1;
        @(posedge clk_sys) cal_fail_up_evt <= 1'b0;
        host.xfer(32'h0600_0006, rd);
        host.xfer(32'h0, rd);
        chk(rd, 32'h06f8_65e6);
        host.xfer(mk5(5'h0d, 3'h1, 7'h41), rd);
        host.xfer(mk5(5'h01, 3'h1, 7'h41), rd);
        host.xfer(32'h0, rd);
        host.xfer(32'h0, rd);
        chk(rd, 32'h06c8_65e6);
        cal_active <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(32'({cal_start_core, cal_fallback_en}), 32'h7);
        host.xfer(32'h1f00_0006, rd);
        host.xfer(32'h0, rd);
        chk(rd, 32'h0000_1234);
        host.xfer(32'h0000_00f7, rd);
        chk(32'(status_mux_pin), 32'h1);
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(32'({status_mux_pin, ref_range, cal_start_core, cal_fallback_en}), 32'h1);
        host.xfer(32'h0, rd);
        host.xfer(32'h0, rd);
        chk(rd, 32'h0);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        print_verdict();
    end
endmodule : synth_readback_and_output_config_test
bind srb_config_top srb_config_top_props u_props (.clk_sys, .resetn, .ser_le, .cal_active, .core_preset_valid,
    .status_mux_pin, .rf_out_a_en, .rf_out_b_en, .out_b_source, .ref_range, .cal_start_core, .cal_fallback_en);
